// File: lhbp_defines.svh
// timing and field constants for the local host bus port
// assumes inclusion by bare name from the design files
`ifndef LHBP_DEFINES_SVH
`define LHBP_DEFINES_SVH
`define LHBP_DATA_W        16
`define LHBP_SEL_W         3
`define LHBP_REGS          8
`define LHBP_RDY_DELAY     2'h1
`define LHBP_WR_RDY_CYC    2'h2
`define LHBP_RD_RDY_CYC    2'h2
`define LHBP_CAPTURE_EDGE  2'h2
`endif

// File: lhbp_pkg.sv
// types shared by the local host bus port, its host model and the bench
// assumes lhbp_defines.svh is on the include path
`include "lhbp_defines.svh"
package lhbp_pkg;
  typedef enum logic [2:0] {
    LHBP_IDLE,
    LHBP_SETUP,
    LHBP_WAIT,
    LHBP_READY,
    LHBP_HOLD
  } lhbp_state_t;

  // one host-side request as seen on the pins
  typedef struct packed {
    logic                      selectN;
    logic                      writeStrobeN;
    logic                      readStrobeN;
    logic [`LHBP_SEL_W-1:0]    regSelect;
    logic [`LHBP_DATA_W-1:0]   data;
  } lhbp_req_t;

  // state of the port controller
  typedef struct packed {
    lhbp_state_t               state;
    logic                      isRead;
    logic [1:0]                csCount;
    logic [1:0]                rdyCount;
    logic                      hostReadyN;
    logic                      dataOe;
    logic [`LHBP_DATA_W-1:0]   dataOut;
    logic                      wrEn;
    logic [`LHBP_SEL_W-1:0]    wrAddr;
    logic [`LHBP_DATA_W-1:0]   wrData;
  } lhbp_ctl_t;
endpackage : lhbp_pkg

// File: lhbp_reg_store.sv
// small register store behind the host port
// assumes one clock; read data registered, one cycle latency
`timescale 1ns/1ps
`include "lhbp_defines.svh"
module lhbp_reg_store #(
  parameter int DATA_W = `LHBP_DATA_W,
  parameter int SEL_W  = `LHBP_SEL_W,
  parameter int DEPTH  = `LHBP_REGS
) (
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic              wrEn,
  input  wire logic [SEL_W-1:0]  wrAddr,
  input  wire logic [DATA_W-1:0] wrData,
  input  wire logic [SEL_W-1:0]  rdAddr,
  output logic      [DATA_W-1:0] rdData
);
  logic [DATA_W-1:0] mem [DEPTH];

  // one write port per entry, registered read
  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_entry
      always_ff @(posedge clock or negedge arst_n)
      begin
        if (!arst_n)
          mem[i] <= '0;
        else if (wrEn && wrAddr == SEL_W'(i))
          mem[i] <= wrData;
      end
    end
  endgenerate

  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
      rdData <= '0;
    else
      rdData <= mem[rdAddr];
  end
endmodule : lhbp_reg_store

// File: lhbp_host_port.sv
// local host bus port: chip select, register select, strobes, ready
// assumes host pins synchronous to clock; bus wire resolved outside
//
// What this block does
// - ready asserted one cycle after write strobe
// - write ready ends after at most two
// - write data captured at second edge after select
// - read ready one cycle late, two long
`timescale 1ns/1ps
`include "lhbp_defines.svh"
module lhbp_host_port (
  input  wire logic                     clock,
  input  wire logic                     arst_n,
  input  wire logic                     selectN,
  input  wire logic [`LHBP_SEL_W-1:0]   regSelect,
  input  wire logic                     writeStrobeN,
  input  wire logic                     readStrobeN,
  input  wire logic [`LHBP_DATA_W-1:0]  dataIn,
  output logic      [`LHBP_DATA_W-1:0]  dataOut,
  output logic                          dataOe,
  output logic                          hostReadyN,
  output logic                          wrEn,
  output logic      [`LHBP_SEL_W-1:0]   wrAddr,
  output logic      [`LHBP_DATA_W-1:0]  wrData
);
  lhbp_pkg::lhbp_ctl_t ctl;
  lhbp_pkg::lhbp_ctl_t next_ctl;
  logic [`LHBP_DATA_W-1:0] rdData;
  logic wrAct;
  logic rdAct;
  logic csAct;

  assign csAct = !selectN;
  assign wrAct = csAct && !writeStrobeN;
  assign rdAct = csAct && !readStrobeN;

  // register contents; read data valid one cycle after address
  lhbp_reg_store #(
    .DATA_W (`LHBP_DATA_W),
    .SEL_W  (`LHBP_SEL_W),
    .DEPTH  (`LHBP_REGS)
  ) u_store (
    .clock  (clock),
    .arst_n (arst_n),
    .wrEn   (ctl.wrEn),
    .wrAddr (ctl.wrAddr),
    .wrData (ctl.wrData),
    .rdAddr (regSelect),
    .rdData (rdData)
  );

  // next-state logic of the port controller
  always_comb
  begin
    next_ctl = ctl;
    next_ctl.wrEn = 1'b0;
    // count edges since chip select went active
    if (!csAct)
      next_ctl.csCount = 2'h0;
    else if (ctl.csCount != 2'h3)
      next_ctl.csCount = ctl.csCount + 2'h1;
    // capture write data on the second edge after select
    if (wrAct && ctl.csCount == `LHBP_CAPTURE_EDGE - 2'h1)
    begin
      next_ctl.wrEn   = 1'b1;
      next_ctl.wrAddr = regSelect;
      next_ctl.wrData = dataIn;
    end
    // bus driven only in the cycle after a selected read strobe is sampled active
    next_ctl.dataOe  = rdAct;
    next_ctl.dataOut = rdData;
    case (ctl.state)
      lhbp_pkg::LHBP_IDLE:
      begin
        next_ctl.hostReadyN = 1'b1;
        if (wrAct || rdAct)
        begin
          // ready goes low at the next edge: one cycle after strobe
          next_ctl.isRead     = rdAct;
          next_ctl.hostReadyN = 1'b0;
          next_ctl.rdyCount   = `LHBP_RDY_DELAY;
          next_ctl.state      = lhbp_pkg::LHBP_READY;
        end
      end
      lhbp_pkg::LHBP_READY:
      begin
        if (!ctl.isRead && !wrAct)
        begin
          next_ctl.hostReadyN = 1'b1; // write ended early
          next_ctl.state      = lhbp_pkg::LHBP_IDLE;
        end
        else if (ctl.rdyCount == (ctl.isRead ? `LHBP_RD_RDY_CYC
                                              : `LHBP_WR_RDY_CYC))
        begin
          next_ctl.hostReadyN = 1'b1;
          next_ctl.state      = lhbp_pkg::LHBP_HOLD;
        end
        else
          next_ctl.rdyCount = ctl.rdyCount + 2'h1;
      end
      lhbp_pkg::LHBP_HOLD:
      begin
        // wait for the strobe to drop before the next transfer
        next_ctl.hostReadyN = 1'b1;
        if (!wrAct && !rdAct)
          next_ctl.state = lhbp_pkg::LHBP_IDLE;
      end
      default:
      begin
        next_ctl.hostReadyN = 1'b1;
        next_ctl.state      = lhbp_pkg::LHBP_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctl            <= '0;
      ctl.state      <= lhbp_pkg::LHBP_IDLE;
      ctl.hostReadyN <= 1'b1;
    end
    else
      ctl <= next_ctl;
  end

  // outputs straight from flip-flops
  assign hostReadyN = ctl.hostReadyN;
  assign dataOe     = ctl.dataOe;
  assign dataOut    = ctl.dataOut;
  assign wrEn       = ctl.wrEn;
  assign wrAddr     = ctl.wrAddr;
  assign wrData     = ctl.wrData;

  // assertions
  // strobe seen in idle: start of a write or of a read
  sequence s_wrStart;
    (ctl.state == lhbp_pkg::LHBP_IDLE) && wrAct;
  endsequence

  sequence s_rdStart;
    (ctl.state == lhbp_pkg::LHBP_IDLE) && rdAct;
  endsequence

  // write strobe on the edge after select went low
  sequence s_capEdge;
    $fell(selectN) ##1 wrAct;
  endsequence

  sequence s_rdPulse;
    !hostReadyN [*2] ##1 hostReadyN;
  endsequence

  AST_WR_RDY_DELAY: assert property (
    @(posedge clock) disable iff (!arst_n)
    s_wrStart |=> !hostReadyN)
    else $error("ready not low one cycle after write strobe");

  AST_WR_RDY_MAX: assert property (
    @(posedge clock) disable iff (!arst_n)
    s_wrStart |-> ##3 hostReadyN)
    else $error("write ready held longer than two cycles");

  AST_RD_RDY: assert property (
    @(posedge clock) disable iff (!arst_n)
    s_rdStart |=> s_rdPulse)
    else $error("read ready not a two-cycle pulse");

  AST_WR_CAPTURE: assert property (
    @(posedge clock) disable iff (!arst_n)
    s_capEdge |=> wrEn && wrData == $past(dataIn))
    else $error("write data not captured at second edge");

  AST_DRIVE_ONLY_READ: assert property (
    @(posedge clock) disable iff (!arst_n)
    dataOe |-> $past(rdAct))
    else $error("bus driven without a selected read");

  AST_RELEASE: assert property (
    @(posedge clock) disable iff (!arst_n)
    $fell(rdAct) |=> !dataOe)
    else $error("bus not released after read strobe");

  AST_RDY_HIGH_IDLE: assert property (
    @(posedge clock) disable iff (!arst_n)
    !wrAct && !rdAct && !$past(wrAct) && !$past(rdAct) |-> hostReadyN)
    else $error("ready low with no strobe");

  AST_WR_ONCE: assert property (
    @(posedge clock) disable iff (!arst_n)
    wrEn |=> !wrEn)
    else $error("write captured twice in one transfer");

  // further write and read checks
  AST_WR_CAPTURE_ADDR: assert property (
    @(posedge clock) disable iff (!arst_n)
    s_capEdge |=> wrAddr == $past(regSelect))
    else $error("write address not captured at second edge");

  AST_WR_CAPTURE_ONLY: assert property (
    @(posedge clock) disable iff (!arst_n)
    wrEn |-> $past(selectN, 3) && !$past(selectN, 2))
    else $error("write captured away from second edge");

  AST_RDY_MAX_TWO: assert property (
    @(posedge clock) disable iff (!arst_n)
    $fell(hostReadyN) |-> ##2 hostReadyN)
    else $error("ready low for more than two cycles");

  AST_RD_DRIVE: assert property (
    @(posedge clock) disable iff (!arst_n)
    s_rdStart |=> dataOe)
    else $error("bus not driven during read");

  AST_WR_NO_DRIVE: assert property (
    @(posedge clock) disable iff (!arst_n)
    wrAct |=> !dataOe)
    else $error("bus driven during write");
endmodule : lhbp_host_port

// File: lhbp_host_model.sv
// host bus master model for the local host bus port
// assumes one clock; the bench resolves the shared data wire
`timescale 1ns/1ps
module lhbp_host_model (
  input  wire logic           clock,
  input  wire logic           rdyN,
  input  wire logic           oe,
  input  wire logic [15:0]    rd,
  input  wire logic           we,
  input  wire logic [2:0]     wa,
  input  wire logic [15:0]    wd,
  output lhbp_pkg::lhbp_req_t req
);
  int          first;
  int          len;
  int          hits;
  logic [15:0] rdSeen;
  logic [15:0] wdSeen;
  logic [2:0]  waSeen;
  logic        oeOn;
  logic        oeOff;
  // idle bus, nothing selected
  initial req = '{1'b1, 1'b1, 1'b1, 3'h0, 16'h0};
  // one transfer, strobe held for hold cycles
  task xfer(input logic w, input logic [2:0] a,
            input logic [15:0] d, input int hold);
    first = 0;
    len = 0;
    hits = 0;
    @(posedge clock);
    #1;
    req.selectN = 1'b0;
    req.regSelect = a;
    req.data = w ? d : ~req.data; // released line keeps no stale value
    @(posedge clock);
    #1;
    req.writeStrobeN = ~w;
    req.readStrobeN = w;
    for (int k = 1; k <= hold + 2; k++)
    begin
      @(posedge clock);
      #1;
      if (rdyN === 1'b0 && first == 0)
        first = k;
      if (rdyN === 1'b0)
        len++;
      if (we === 1'b1)
      begin
        hits++;
        waSeen = wa;
        wdSeen = wd;
      end
      if (k == 1)
        rdSeen = rd;
      if (k == 1)
        oeOn = oe;
      oeOff = oe;
      if (k == hold)
        req = '{1'b1, 1'b1, 1'b1, a, ~req.data};
    end
    repeat (2) @(posedge clock);
  endtask : xfer
endmodule : lhbp_host_model

// File: test_local_host_bus_port.sv
// self-checking bench for the local host bus port
// assumes one clock; bench resolves the shared data wire
`timescale 1ns/1ps
module test_local_host_bus_port;
  logic                clock;
  logic                arst_n;
  logic                dataOe, hostReadyN, wrEn;
  logic [2:0]          wrAddr;
  logic [15:0]         dataOut, wrData, busWire;
  lhbp_pkg::lhbp_req_t req;
  int                  failCount = 0;
  int                  checks = 0;
  // device drives the wire while enabled, else the host
  assign busWire = dataOe ? dataOut : req.data;
  lhbp_host_port DUT (.clock(clock), .arst_n(arst_n),
    .selectN(req.selectN), .regSelect(req.regSelect),
    .writeStrobeN(req.writeStrobeN), .readStrobeN(req.readStrobeN),
    .dataIn(busWire), .dataOut(dataOut), .dataOe(dataOe),
    .hostReadyN(hostReadyN), .wrEn(wrEn), .wrAddr(wrAddr),
    .wrData(wrData));
  lhbp_host_model host (.clock(clock), .rdyN(hostReadyN), .oe(dataOe),
    .rd(dataOut), .we(wrEn), .wa(wrAddr), .wd(wrData), .req(req));
  // free-running clock
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task check(input string n, input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      failCount++;
    end
  endtask : check
  function automatic logic [15:0] pat(input int i);
    return {4{i[3:0]}} ^ 16'hF00F;
  endfunction : pat
  task check_timing(input logic [15:0] w);
    check("ready delay", 16'(host.first), 16'h1);
    check("ready width", 16'(host.len), w);
  endtask : check_timing
  task test_write_all;
    for (int i = 0; i < 8; i++)
    begin
      host.xfer(1'b1, 3'(i), pat(i), 2);
      check_timing(16'h2);
      check("write count", 16'(host.hits), 16'h1);
      check("write addr", {13'h0, host.waSeen}, 16'(i));
      check("write data", host.wdSeen, pat(i));
      check("write drive", {15'h0, host.oeOn}, 16'h0);
    end
    $display("test_write_all done");
  endtask : test_write_all
  task test_long_write;
    host.xfer(1'b1, 3'h3, 16'h5AA5, 4);
    check_timing(16'h2);
    check("long data", host.wdSeen, 16'h5AA5);
    check("long count", 16'(host.hits), 16'h1);
    $display("test_long_write done");
  endtask : test_long_write
  task test_read_all;
    for (int i = 0; i < 8; i++)
    begin
      host.xfer(1'b0, 3'(i), 16'h0, 3);
      check_timing(16'h2);
      check("read data", host.rdSeen, i == 3 ? 16'h5AA5 : pat(i));
      check("read drive", {15'h0, host.oeOn}, 16'h1);
      check("read release", {15'h0, host.oeOff}, 16'h0);
      check("read no write", 16'(host.hits), 16'h0);
    end
    $display("test_read_all done");
  endtask : test_read_all
  task test_reset_clears;
    #1;
    arst_n = 1'b0;
    repeat (2) @(posedge clock);
    check("reset ready", {15'h0, hostReadyN}, 16'h1);
    check("reset drive", {15'h0, dataOe}, 16'h0);
    check("reset write", {15'h0, wrEn}, 16'h0);
    #1;
    arst_n = 1'b1;
    host.xfer(1'b0, 3'h3, 16'h0, 3);
    check("cleared data", host.rdSeen, 16'h0);
    $display("test_reset_clears done");
  endtask : test_reset_clears
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, failCount);
    if (failCount == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  // hang guard
  initial
  begin
    #500000;
    failCount++;
    print_verdict;
  end
  // reset, then the scenarios
  initial
  begin
    arst_n = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    arst_n = 1'b1;
    test_write_all;
    test_long_write;
    test_read_all;
    test_reset_clears;
    print_verdict;
  end
endmodule : test_local_host_bus_port
